// ==== include/spim_pkg.sv ====
// Package with register map, field layout and types of the serial master engine.
package spim_pkg;
    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] SPIM_CTRL_ADDR = 32'h4000_8000;
    localparam logic [31:0] SPIM_MODE_ADDR = 32'h4000_8004;
    localparam logic [31:0] SPIM_RXD_ADDR = 32'h4000_8008;
    localparam logic [31:0] SPIM_TXD_ADDR = 32'h4000_800C;
    localparam logic [31:0] SPIM_STAT_ADDR = 32'h4000_8010;
    localparam logic [31:0] SPIM_SCFG0_ADDR = 32'h4000_8030;
    localparam logic [31:0] SPIM_WPROT_ADDR = 32'h4000_80E4;
    localparam int SPIM_NUM_SCFG = 4;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_DISABLE_BIT = 1;
    localparam int MODE_MASTER_BIT = 0;
    localparam int MODE_VARSEL_BIT = 1;
    localparam int MODE_DECODE_BIT = 2;
    localparam int MODE_FAULTOFF_BIT = 4;
    localparam int MODE_WAITRD_BIT = 5;
    localparam int MODE_LOOP_BIT = 7;
    localparam int SEL_FIELD_LSB = 16;
    localparam int GAP_FIELD_LSB = 24;
    localparam int SCFG_DIV_LSB = 8;
    localparam int SCFG_DLY_LSB = 24;
    localparam int WPROT_LOCK_BIT = 0;
    localparam int STAT_RXFULL_BIT = 0;
    localparam int STAT_SHIFTER_IDLE_FLAG_BIT = 1;
    localparam int STAT_FAULT_BIT = 2;
    localparam int STAT_OVR_BIT = 3;
    localparam int STAT_IDLE_BIT = 9;
    localparam int STAT_EN_BIT = 16;

    // ------------------------------------------------------------------
    // Reset values and the last bit index
    // ------------------------------------------------------------------
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] SCFG_RESET = 32'h0000_0100;
    localparam logic [3:0] SEL_IDLE = 4'hF;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LEAD = 4'h2,
        ST_SHIFT = 4'h4,
        ST_TRAIL = 4'h8
    } spim_state_type;

    typedef struct packed {
        logic enabled;
        logic shifter_idle;
        logic rx_overrun;
        logic mode_fault;
        logic tx_empty;
        logic rx_full;
    } spim_status_type;
endpackage

// ==== rtl/spim_baud_div.sv ====
// Programmable divider that produces one-cycle tick enables for the serial clock.
`timescale 1ns/100ps
`default_nettype none
module spim_baud_div
    import spim_pkg::*;
#(
    parameter int DIV_W = 8
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [DIV_W-1:0] divisor,
    output logic tick
);
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] limit;

    // A divisor of zero behaves as one so the link never stalls.
    assign limit = (divisor == '0) ? DIV_W'(1) : divisor;
    assign tick = run && (cnt_q == limit - DIV_W'(1));

    always_ff @(posedge clk)
    begin
        if (sys_rst || !run || tick)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_q + DIV_W'(1);
        end
    end
endmodule // spim_baud_div
`default_nettype wire

// ==== rtl/spim_engine.sv ====
// Master-mode transfer engine of the serial peripheral interface.
//
// Notes on behaviour
// - Master makes clock and drives selects.
// - Two holding registers, one shared shifter.
// - Write when idle starts transfer at once.
// - Input line shifts into same shifter.
// - Word written mid-transfer waits, then follows.
// - Transmit empty clears on write, sets on load.
// - Transmit empty requests next word from DMA.
// - Shifter idle sets after inter-word delay.
// - Enable sets transmit empty and idle flags.
// - Receive full sets on load, clears on read.
// - Unread word overwritten sets overrun; status read clears.
// - Wait-for-read holds transfer while receive full.
// - Mode bits select master role, select mode.
// - Decode drives encoded value, else one line.
// - Decode picks config register by select group.
// - Fault-detect-off bit disables mode fault detection.
// - Mode writes ignored while write lock set.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module spim_engine
    import spim_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic miso_i,
    input wire logic fault_n_i,
    output logic mosi_o,
    output logic serial_clock_pin,
    output logic [3:0] slave_select_lines,
    output logic tx_dma_req
);
    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [31:0] serial_mode_reg_q;
    logic [31:0] select_config_q [SPIM_NUM_SCFG];
    logic write_lock_bit_q;
    logic enabled_q;
    logic [DATA_W-1:0] tx_holding_reg_q;
    logic [3:0] tx_sel_q;
    logic [DATA_W-1:0] rx_holding_reg_q;
    logic [31:0] bus_rdata_q;
    spim_status_type stat_q;
    logic tx_full;

    // ------------------------------------------------------------------
    // Engine state
    // ------------------------------------------------------------------
    spim_state_type state_q;
    logic [DATA_W-1:0] shift_q;
    logic [2:0] bit_q;
    logic sample_q;
    logic sclk_q;
    logic [7:0] delay_q;
    logic [3:0] cur_sel_q;
    logic [3:0] sel_out_q;
    logic [1:0] miso_sync_q;
    logic [1:0] fault_sync_q;

    // ------------------------------------------------------------------
    // Decoded strobes and fields
    // ------------------------------------------------------------------
    logic wr_ctrl, wr_mode, wr_txd, rd_rxd, rd_stat, wr_wprot;
    logic master, var_sel, decode_on, fault_off, wait_rd, loopback;
    logic start, word_done, trail_done, tick, fault_hit;
    logic [3:0] next_sel;
    logic [1:0] cfg_idx;
    logic [31:0] cfg_word;
    logic miso_eff;

    assign wr_ctrl = bus_wr && (bus_addr == SPIM_CTRL_ADDR);
    assign wr_mode = bus_wr && (bus_addr == SPIM_MODE_ADDR);
    assign wr_txd = bus_wr && (bus_addr == SPIM_TXD_ADDR);
    assign wr_wprot = bus_wr && (bus_addr == SPIM_WPROT_ADDR);
    assign rd_rxd = bus_rd && (bus_addr == SPIM_RXD_ADDR);
    assign rd_stat = bus_rd && (bus_addr == SPIM_STAT_ADDR);

    assign master = serial_mode_reg_q[MODE_MASTER_BIT];
    assign var_sel = serial_mode_reg_q[MODE_VARSEL_BIT];
    assign decode_on = serial_mode_reg_q[MODE_DECODE_BIT];
    assign fault_off = serial_mode_reg_q[MODE_FAULTOFF_BIT];
    assign wait_rd = serial_mode_reg_q[MODE_WAITRD_BIT];
    assign loopback = serial_mode_reg_q[MODE_LOOP_BIT];
    assign tx_full = !stat_q.tx_empty;

    // Select for the next word: the mode field in fixed mode, the word's own
    // field in variable mode.
    assign next_sel = var_sel ? tx_sel_q : serial_mode_reg_q[SEL_FIELD_LSB +: 4];

    // Config register that governs the active select.
    always_comb
    begin
        if (decode_on)
        begin
            cfg_idx = cur_sel_q[3:2];
        end
        else if (!cur_sel_q[0])
        begin
            cfg_idx = 2'h0;
        end
        else if (!cur_sel_q[1])
        begin
            cfg_idx = 2'h1;
        end
        else if (!cur_sel_q[2])
        begin
            cfg_idx = 2'h2;
        end
        else
        begin
            cfg_idx = 2'h3;
        end
    end
    assign cfg_word = select_config_q[cfg_idx];

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            miso_sync_q <= 2'h0;
            fault_sync_q <= 2'h3;
        end
        else
        begin
            miso_sync_q <= {miso_sync_q[0], miso_i};
            fault_sync_q <= {fault_sync_q[0], fault_n_i};
        end
    end
    assign miso_eff = loopback ? shift_q[DATA_W-1] : miso_sync_q[1];
    // A low fault pin while mastering means another master drives the bus.
    assign fault_hit = enabled_q && master && !fault_off && !fault_sync_q[1];

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            write_lock_bit_q <= 1'b0;
        end
        else if (wr_wprot)
        begin
            write_lock_bit_q <= bus_wdata[WPROT_LOCK_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            serial_mode_reg_q <= MODE_RESET;
        end
        else if (wr_mode && !write_lock_bit_q)
        begin
            serial_mode_reg_q <= bus_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        for (int i = 0; i < SPIM_NUM_SCFG; i++)
        begin
            if (sys_rst)
            begin
                select_config_q[i] <= SCFG_RESET;
            end
            else if (bus_wr && (bus_addr == SPIM_SCFG0_ADDR + 32'(4 * i)))
            begin
                select_config_q[i] <= bus_wdata;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            enabled_q <= 1'b0;
        end
        else if (wr_ctrl && bus_wdata[CTRL_DISABLE_BIT])
        begin
            enabled_q <= 1'b0;
        end
        else if (wr_ctrl && bus_wdata[CTRL_ENABLE_BIT])
        begin
            enabled_q <= 1'b1;
        end
        else if (fault_hit)
        begin
            enabled_q <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tx_holding_reg_q <= '0;
            tx_sel_q <= SEL_IDLE;
        end
        else if (wr_txd)
        begin
            tx_holding_reg_q <= bus_wdata[DATA_W-1:0];
            tx_sel_q <= bus_wdata[SEL_FIELD_LSB +: 4];
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // A transfer may begin only when enabled, mastering, idle and holding a word.
    assign start = enabled_q && master && (state_q == ST_IDLE) && tx_full
        && !(wait_rd && stat_q.rx_full);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stat_q.tx_empty <= 1'b1;
        end
        else if (wr_ctrl && bus_wdata[CTRL_ENABLE_BIT] && !enabled_q)
        begin
            stat_q.tx_empty <= 1'b1;
        end
        else if (wr_txd)
        begin
            stat_q.tx_empty <= 1'b0;
        end
        else if (start)
        begin
            stat_q.tx_empty <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stat_q.rx_full <= 1'b0;
        end
        else if (word_done)
        begin
            stat_q.rx_full <= 1'b1;
        end
        else if (rd_rxd)
        begin
            stat_q.rx_full <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stat_q.rx_overrun <= 1'b0;
        end
        else if (word_done && stat_q.rx_full && !rd_rxd)
        begin
            stat_q.rx_overrun <= 1'b1;
        end
        else if (rd_stat)
        begin
            stat_q.rx_overrun <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stat_q.mode_fault <= 1'b0;
        end
        else if (fault_hit)
        begin
            stat_q.mode_fault <= 1'b1;
        end
        else if (rd_stat)
        begin
            stat_q.mode_fault <= 1'b0;
        end
    end

    // Idle only once the shifter and the trailing delay have finished.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stat_q.shifter_idle <= 1'b1;
            stat_q.enabled <= 1'b0;
        end
        else
        begin
            stat_q.shifter_idle <= (state_q == ST_IDLE) && !start && !tx_full
                && !wr_txd;
            stat_q.enabled <= enabled_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rx_holding_reg_q <= '0;
        end
        else if (word_done)
        begin
            rx_holding_reg_q <= {shift_q[DATA_W-2:0], sample_q};
        end
    end

    // ------------------------------------------------------------------
    // Serial clock and transfer sequence
    // ------------------------------------------------------------------
    spim_baud_div #(
        .DIV_W(8)
    ) u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(state_q != ST_IDLE),
        .divisor(cfg_word[SCFG_DIV_LSB +: 8]),
        .tick(tick)
    );

    assign word_done = (state_q == ST_SHIFT) && tick && sclk_q && (bit_q == LAST_BIT);
    assign trail_done = (state_q == ST_TRAIL) && (delay_q == 8'h00);

    always_ff @(posedge clk)
    begin
        if (sys_rst || !enabled_q)
        begin
            state_q <= ST_IDLE;
            sclk_q <= 1'b0;
            bit_q <= 3'h0;
            delay_q <= 8'h00;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state_q <= ST_LEAD;
                        delay_q <= serial_mode_reg_q[GAP_FIELD_LSB +: 8];
                    end
                end
                ST_LEAD:
                begin
                    if (tick)
                    begin
                        if (delay_q == 8'h00)
                        begin
                            state_q <= ST_SHIFT;
                        end
                        else
                        begin
                            delay_q <= delay_q - 8'h01;
                        end
                    end
                end
                ST_SHIFT:
                begin
                    if (tick)
                    begin
                        sclk_q <= !sclk_q;
                        if (sclk_q)
                        begin
                            bit_q <= bit_q + 3'h1;
                        end
                        if (word_done)
                        begin
                            state_q <= ST_TRAIL;
                            delay_q <= cfg_word[SCFG_DLY_LSB +: 8];
                        end
                    end
                end
                ST_TRAIL:
                begin
                    if (trail_done)
                    begin
                        state_q <= ST_IDLE;
                    end
                    else if (tick)
                    begin
                        delay_q <= delay_q - 8'h01;
                    end
                end
            endcase
        end
    end

    // Sample on the rising edge, shift on the falling edge, MSB first.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            shift_q <= '0;
            sample_q <= 1'b0;
        end
        else if (start)
        begin
            shift_q <= tx_holding_reg_q;
        end
        else if ((state_q == ST_SHIFT) && tick)
        begin
            if (!sclk_q)
            begin
                sample_q <= miso_eff;
            end
            else
            begin
                shift_q <= {shift_q[DATA_W-2:0], sample_q};
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cur_sel_q <= SEL_IDLE;
            sel_out_q <= SEL_IDLE;
        end
        else
        begin
            if (start)
            begin
                cur_sel_q <= next_sel;
            end
            if ((state_q == ST_IDLE) && !start)
            begin
                sel_out_q <= SEL_IDLE;
            end
            else if (state_q != ST_IDLE)
            begin
                // Decode passes the code on; direct mode drives one line low.
                sel_out_q <= decode_on ? cur_sel_q : ~(4'h1 << cfg_idx);
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bus_rdata_q <= 32'h0000_0000;
        end
        else if (bus_rd)
        begin
            bus_rdata_q <= 32'h0000_0000;
            unique case (bus_addr)
                SPIM_MODE_ADDR: bus_rdata_q <= serial_mode_reg_q;
                SPIM_RXD_ADDR: bus_rdata_q <= 32'(rx_holding_reg_q);
                SPIM_WPROT_ADDR: bus_rdata_q <= 32'(write_lock_bit_q);
                SPIM_STAT_ADDR:
                begin
                    bus_rdata_q[STAT_RXFULL_BIT] <= stat_q.rx_full;
                    bus_rdata_q[STAT_SHIFTER_IDLE_FLAG_BIT] <= stat_q.tx_empty;
                    bus_rdata_q[STAT_FAULT_BIT] <= stat_q.mode_fault;
                    bus_rdata_q[STAT_OVR_BIT] <= stat_q.rx_overrun;
                    bus_rdata_q[STAT_IDLE_BIT] <= stat_q.shifter_idle;
                    bus_rdata_q[STAT_EN_BIT] <= stat_q.enabled;
                end
                SPIM_SCFG0_ADDR: bus_rdata_q <= select_config_q[0];
                SPIM_SCFG0_ADDR + 32'h4: bus_rdata_q <= select_config_q[1];
                SPIM_SCFG0_ADDR + 32'h8: bus_rdata_q <= select_config_q[2];
                SPIM_SCFG0_ADDR + 32'hC: bus_rdata_q <= select_config_q[3];
                default: bus_rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign bus_rdata = bus_rdata_q;
    assign mosi_o = shift_q[DATA_W-1];
    assign serial_clock_pin = sclk_q;
    assign slave_select_lines = sel_out_q;
    assign tx_dma_req = enabled_q && stat_q.tx_empty;
endmodule // spim_engine
`default_nettype wire

// ==== tb/spim_engine_props.sv ====
// Port-level assertions for the serial master engine.
`timescale 1ns/100ps
`default_nettype none
module spim_engine_props
    import spim_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic miso_i,
    input wire logic fault_n_i,
    input wire logic mosi_o,
    input wire logic serial_clock_pin,
    input wire logic [3:0] slave_select_lines,
    input wire logic tx_dma_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_word_start;
        $past(slave_select_lines) == SEL_IDLE && slave_select_lines != SEL_IDLE;
    endsequence
    sequence s_txd_wr;
        bus_wr && bus_addr == SPIM_TXD_ADDR;
    endsequence
    sequence s_ctrl_wr;
        bus_wr && bus_addr == SPIM_CTRL_ADDR;
    endsequence
    reset_idle_a: assert property ($fell(sys_rst) |-> slave_select_lines == SEL_IDLE
        && !serial_clock_pin && !tx_dma_req && bus_rdata == 32'h0)
        else $error("outputs busy after reset");
    clk_parked_a: assert property (slave_select_lines == SEL_IDLE |-> !serial_clock_pin)
        else $error("clock runs without select");
    lead_quiet_a: assert property (s_word_start |-> !serial_clock_pin)
        else $error("clock high at select");
    sel_hold_a: assert property (serial_clock_pin |-> $stable(slave_select_lines))
        else $error("select moved in word");
    mosi_hold_a: assert property (serial_clock_pin |-> $stable(mosi_o))
        else $error("data moved with clock high");
    txd_clear_a: assert property (s_txd_wr |=> !tx_dma_req)
        else $error("request high after write");
    enable_sets_a: assert property (s_ctrl_wr ##0 bus_wdata[1:0] == 2'b01 |-> ##[1:2] tx_dma_req)
        else $error("enable left request low");
    disable_clears_a: assert property (s_ctrl_wr ##0 bus_wdata[1] |-> ##[1:2] !tx_dma_req)
        else $error("request survives disable");
endmodule // spim_engine_props
bind spim_engine spim_engine_props #(.DATA_W(DATA_W)) spim_engine_props_inst (
    .clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .miso_i(miso_i),
    .fault_n_i(fault_n_i), .mosi_o(mosi_o), .serial_clock_pin(serial_clock_pin),
    .slave_select_lines(slave_select_lines), .tx_dma_req(tx_dma_req));
`default_nettype wire

// ==== tb/spim_slave_model.sv ====
// Behavioural slave device on the far side of the serial link.
`timescale 1ns/100ps
`default_nettype none
module spim_slave_model
(
    input wire logic serial_clock_pin,
    input wire logic mosi_o,
    input wire logic [3:0] slave_select_lines,
    input wire logic [7:0] reply,
    output logic miso_i,
    output logic [7:0] got
);
    logic [7:0] sh = 8'h00;
    logic [2:0] n = 3'h0;
    logic sel;
    assign sel = slave_select_lines != 4'hF;
    // A released line shows the inverse of its top bit.
    assign miso_i = sel ? sh[7] : ~sh[7];
    always @(posedge sel) {n, sh} = {3'h0, reply};
    always @(posedge serial_clock_pin) if (sel) got = {got[6:0], mosi_o};
    always @(negedge serial_clock_pin) if (sel) {n, sh} = {n + 3'h1,
        (n == 3'h7) ? reply : {sh[6:0], 1'b0}};
endmodule // spim_slave_model
`default_nettype wire

// ==== tb/tb_spim_engine.sv ====
// Self-checking testbench for the serial master engine.
`timescale 1ns/100ps
`default_nettype none
module tb_spim_engine
    import spim_pkg::*;
;
    logic clk, sys_rst, bus_wr, bus_rd, miso_i, fault_n_i, mosi_o, serial_clock_pin, tx_dma_req;
    logic [31:0] bus_addr, bus_wdata, bus_rdata, rv, seed, mode_v;
    logic [3:0] slave_select_lines;
    logic [7:0] reply, got, dv;
    logic ok;
    logic [3:0] flds [5] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'h5};
    int n_fail, checked;
    spim_engine #(.DATA_W(8)) spim_engine_inst (.clk(clk), .sys_rst(sys_rst),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .miso_i(miso_i), .fault_n_i(fault_n_i), .mosi_o(mosi_o),
        .serial_clock_pin(serial_clock_pin), .slave_select_lines(slave_select_lines),
        .tx_dma_req(tx_dma_req));
    spim_slave_model spim_slave_model_inst (.serial_clock_pin(serial_clock_pin),
        .mosi_o(mosi_o), .slave_select_lines(slave_select_lines), .reply(reply),
        .miso_i(miso_i), .got(got));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] st(input logic rxf, input logic ovr);
        return 32'h0001_0202 | {28'h0, ovr, 2'b00, rxf};
    endfunction
    function automatic logic [3:0] exp_sel(input logic [3:0] f, input logic dec);
        logic [3:0] e;
        e = 4'hF;
        for (int k = 3; k >= 0; k--)
            if (!f[k]) e = ~(4'h1 << k);
        return dec ? f : e;
    endfunction
    task automatic final_report(input bit timed_out);
        if (timed_out) n_fail++;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string m);
        rd(a, rv);
        chk(rv, e, m);
    endtask
    task automatic wait_idle();
        int q = 0;
        for (int n = 0; n < 3000 && q < 40; n++)
        begin
            @(posedge clk);
            q = (slave_select_lines === 4'hF) ? q + 1 : 0;
        end
        if (q < 40) final_report(1);
    endtask
    task automatic wait_sel(input int lim);
        ok = 1'b0;
        for (int n = 0; n < lim && !ok; n++)
        begin
            @(posedge clk);
            ok = slave_select_lines !== 4'hF;
        end
    endtask
    task automatic xfer(input logic [31:0] m, input logic [7:0] d);
        wr(SPIM_MODE_ADDR, m);
        wr(SPIM_TXD_ADDR, {24'h0, d});
        wait_sel(40);
        chk({31'h0, ok}, 32'h1, "start");
        chk({28'h0, slave_select_lines}, {28'h0, exp_sel(m[19:16], m[2])}, "selects");
        wait_idle();
        rdchk(SPIM_STAT_ADDR, st(1, 0), "rx full");
        rdchk(SPIM_RXD_ADDR, {24'h0, reply}, "rx data");
        chk({24'h0, got}, {24'h0, d}, "tx data");
        rdchk(SPIM_STAT_ADDR, st(0, 0), "rx cleared");
    endtask
    task automatic fault_pulse();
        fault_n_i <= 1'b0;
        repeat (4) @(posedge clk);
        fault_n_i <= 1'b1;
        repeat (4) @(posedge clk);
        rd(SPIM_STAT_ADDR, rv);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        {sys_rst, bus_wr, bus_rd, fault_n_i} = 4'b1001;
        {bus_addr, bus_wdata, reply} = 72'h0;
        seed = 32'h8afe;
        n_fail = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rdchk(SPIM_MODE_ADDR, MODE_RESET, "mode reset");
        rdchk(32'h4000_8020, 32'h0, "unmapped read");
        for (int i = 0; i < SPIM_NUM_SCFG; i++)
            wr(SPIM_SCFG0_ADDR + 32'(4 * i), 32'h0000_0400);
        rdchk(SPIM_SCFG0_ADDR, 32'h0000_0400, "divisor");
        wr(SPIM_CTRL_ADDR, 32'h1);
        rdchk(SPIM_STAT_ADDR, st(0, 0), "enable flags");
        $display("test reset and enable done");
        for (int i = 0; i < 5; i++)
        begin
            mode_v = 32'h1 | (i == 4 ? 32'h4 : 32'h0) | {12'h0, flds[i], 16'h0};
            dv = (i == 3) ? 8'hFF : xs();
            reply = xs();
            xfer(mode_v, dv);
        end
        $display("test select modes done");
        reply = xs();
        dv = xs();
        wr(SPIM_MODE_ADDR, 32'h000E_0001);
        wr(SPIM_TXD_ADDR, {24'h0, xs()});
        wr(SPIM_TXD_ADDR, {24'h0, dv});
        @(posedge clk);
        chk({31'h0, tx_dma_req}, 32'h0, "word waits");
        wait_idle();
        rdchk(SPIM_STAT_ADDR, st(1, 1), "overrun");
        rdchk(SPIM_RXD_ADDR, {24'h0, reply}, "second word");
        chk({24'h0, got}, {24'h0, dv}, "queued word sent");
        rdchk(SPIM_STAT_ADDR, st(0, 0), "overrun cleared");
        $display("test overrun done");
        wr(SPIM_MODE_ADDR, 32'h000E_0021);
        wr(SPIM_TXD_ADDR, {24'h0, xs()});
        wait_idle();
        wr(SPIM_TXD_ADDR, 32'h0000_00A5);
        wait_sel(60);
        chk({31'h0, ok}, 32'h0, "held by unread");
        rdchk(SPIM_RXD_ADDR, {24'h0, reply}, "unread word");
        wait_sel(60);
        chk({31'h0, ok}, 32'h1, "released");
        wait_idle();
        chk({24'h0, got}, 32'h0000_00A5, "held word sent");
        rdchk(SPIM_RXD_ADDR, {24'h0, reply}, "drain");
        $display("test wait for read done");
        fault_pulse();
        chk(rv & 32'h0001_0004, 32'h0000_0004, "fault detected");
        wr(SPIM_MODE_ADDR, 32'h000E_0011);
        wr(SPIM_CTRL_ADDR, 32'h1);
        fault_pulse();
        chk(rv & 32'h0001_0004, 32'h0001_0000, "fault ignored");
        $display("test mode fault done");
        wr(SPIM_WPROT_ADDR, 32'h1);
        wr(SPIM_MODE_ADDR, 32'h0);
        rdchk(SPIM_MODE_ADDR, 32'h000E_0011, "mode locked");
        wr(SPIM_WPROT_ADDR, 32'h0);
        wr(SPIM_CTRL_ADDR, 32'h2);
        repeat (3) @(posedge clk);
        chk({31'h0, tx_dma_req}, 32'h0, "disabled");
        $display("test lock and disable done");
        final_report(0);
    end
endmodule // tb_spim_engine
`default_nettype wire
